// File: logic/ictm_consts.svh
// Timing figures and field codes for the instruction cycle timing model
`ifndef ICTM_CONSTS_SVH
`define ICTM_CONSTS_SVH
// Table geometry
`define ICTM_NUM_CASES 37
`define ICTM_IDX_W 6
`define ICTM_ROW_W 48
// Row field positions: best, cache, worst, rd, pf, wr (8 bits each)
`define ICTM_F_BEST 47:40
`define ICTM_F_CACHE 39:32
`define ICTM_F_WORST 31:24
`define ICTM_F_RD 23:16
`define ICTM_F_PF 15:8
`define ICTM_F_WR 7:0
// Field span limit for one operand cycle, in bytes
`define ICTM_ONE_CYCLE_BYTES 4'h4
// Stack copy scaling per operand transfer
`define ICTM_CLK_PER_XFER 8'h06
`define ICTM_RW_PER_XFER 8'h01
// Op codes
`define ICTM_OP_FIELD_TEST 5'h00
`define ICTM_OP_FIELD_TOGGLE 5'h01
`define ICTM_OP_FIELD_CLEAR 5'h02
`define ICTM_OP_FIELD_SET 5'h03
`define ICTM_OP_FIELD_EXTS 5'h04
`define ICTM_OP_FIELD_EXTU 5'h05
`define ICTM_OP_FIELD_INSERT 5'h06
`define ICTM_OP_FIELD_FFO 5'h07
`define ICTM_OP_BR_TAKEN 5'h08
`define ICTM_OP_BR_NT_B 5'h09
`define ICTM_OP_BR_NT_W 5'h0a
`define ICTM_OP_BR_NT_L 5'h0b
`define ICTM_OP_DEC_NOT_EXP 5'h0c
`define ICTM_OP_DEC_EXP 5'h0d
`define ICTM_OP_DEC_TRUE 5'h0e
`define ICTM_OP_CALL_T0 5'h0f
`define ICTM_OP_CALL_T1_NC 5'h10
`define ICTM_OP_CALL_T1_NC2 5'h11
`define ICTM_OP_CALL_T1_COPY 5'h12
`define ICTM_OP_CAS_OK 5'h13
`define ICTM_OP_CAS_FAIL 5'h14
`define ICTM_OP_CASD_OK 5'h15
`define ICTM_OP_CASD_FAIL 5'h16
`define ICTM_OP_JUMP 5'h17
`define ICTM_OP_JSUB 5'h18
`define ICTM_OP_SHIFT 5'h19
// Table index bases
`define ICTM_IDX_FIELD 6'h00
`define ICTM_IDX_BR 6'h18
`define ICTM_IDX_CTRL 6'h1f
// Row step per field op and row offsets of the memory forms
`define ICTM_ROWS_PER_FIELD 6'h3
`define ICTM_ROW_MEM_ONE 6'h1
`define ICTM_ROW_MEM_TWO 6'h2
// Stack copy call row and the 5/8/8 register row used for shifts
`define ICTM_IDX_COPY 6'h22
`define ICTM_IDX_SHIFT 6'h0c
`endif

// File: logic/ictm_pkg.sv
// Types shared by the instruction cycle timing model
package ictm_pkg;
   // Request decode state
   typedef enum logic [2:0] {
      ICTM_IDLE = 3'b001,
      ICTM_LOOK = 3'b010,
      ICTM_DONE = 3'b100
   } ictm_state_t;
   // Register state of the top module
   typedef struct packed {
      ictm_state_t st;
      logic [5:0] idx;
      logic [7:0] xfer;
      logic addr_add;
      logic valid;
      logic [7:0] best;
      logic [7:0] cache;
      logic [7:0] worst;
      logic [7:0] rd;
      logic [7:0] pf;
      logic [7:0] wr;
      logic add_ea;
   } ictm_regs_t;
endpackage

// File: logic/ictm_rom.sv
// Timing table held as a registered lookup
`timescale 1ns/1ps
`include "ictm_consts.svh"
module ictm_rom
   import ictm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Lookup
   input wire logic [5:0] idx,
   output logic [47:0] row_q
);
   logic [47:0] row_d; // Row chosen this cycle
   // Table: best, cache, worst, r, p, w
   always_comb begin
      case (idx)
         6'h00: row_d = 48'h03_06_07_00_01_00;
         6'h01: row_d = 48'h0b_0b_0c_01_01_00;
         6'h02: row_d = 48'h0f_0f_10_02_01_00;
         6'h03: row_d = 48'h09_0c_0c_00_01_00;
         6'h04: row_d = 48'h10_10_10_01_01_01;
         6'h05: row_d = 48'h18_18_18_02_01_02;
         6'h06: row_d = 48'h09_0c_0c_00_01_00;
         6'h07: row_d = 48'h10_10_10_01_01_01;
         6'h08: row_d = 48'h18_18_18_02_01_02;
         6'h09: row_d = 48'h09_0c_0c_00_01_00;
         6'h0a: row_d = 48'h10_10_10_01_01_01;
         6'h0b: row_d = 48'h18_18_18_02_01_02;
         6'h0c: row_d = 48'h05_08_08_00_01_00;
         6'h0d: row_d = 48'h0d_0d_0d_01_01_00;
         6'h0e: row_d = 48'h12_12_12_02_01_00;
         6'h0f: row_d = 48'h05_08_08_00_01_00;
         6'h10: row_d = 48'h0d_0d_0d_01_01_00;
         6'h11: row_d = 48'h12_12_12_02_01_00;
         6'h12: row_d = 48'h07_0a_0a_00_01_00;
         6'h13: row_d = 48'h0e_0e_0f_01_01_01;
         6'h14: row_d = 48'h14_14_15_02_01_02;
         6'h15: row_d = 48'h0f_12_12_00_01_00;
         6'h16: row_d = 48'h18_18_18_01_01_00;
         6'h17: row_d = 48'h20_20_20_02_01_00;
         6'h18: row_d = 48'h03_06_09_00_02_00;
         6'h19: row_d = 48'h01_04_05_00_01_00;
         6'h1a: row_d = 48'h03_06_07_00_01_00;
         6'h1b: row_d = 48'h03_06_09_00_02_00;
         6'h1c: row_d = 48'h03_06_09_00_02_00;
         6'h1d: row_d = 48'h07_0a_0a_00_03_00;
         6'h1e: row_d = 48'h03_06_07_00_01_00;
         6'h1f: row_d = 48'h1c_1e_24_02_02_06;
         6'h20: row_d = 48'h30_32_38_05_02_08;
         6'h21: row_d = 48'h37_39_40_06_02_08;
         6'h22: row_d = 48'h3f_41_47_07_02_08;
         6'h23: row_d = 48'h0f_0f_10_01_01_01;
         6'h24: row_d = 48'h0c_0c_0d_01_01_00;
         6'h25: row_d = 48'h17_19_1c_02_02_02;
         6'h26: row_d = 48'h13_16_19_02_02_00;
         6'h27: row_d = 48'h01_04_07_00_02_00;
         6'h28: row_d = 48'h03_05_0b_00_02_01;
         default: row_d = 48'h00_00_00_00_00_00;
      endcase
   end
   // Registered read data
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         row_q <= 48'h0;
      end else begin
         row_q <= row_d;
      end
   end
endmodule // ictm_rom

// File: logic/ictm_top.sv
// Instruction cycle timing model: per case clock and bus cycle counts
//
// What this block does
// [RULE1] 32-bit field over five bytes: two operand cycles
// [RULE2] Field within four bytes: one operand cycle
// [RULE3] Decrement-branch, not expired: 3/6/9, two prefetches
// [RULE4] Decrement-branch, expired: 7/10/10, three prefetches
// [RULE5] Stack copy call: 63+6n, reads 7+n, writes 8+n
// [RULE6] Memory field and single swap: add address time
// [RULE7] Jump adds address time; 1/4/7
// [RULE8] Branch timings complete; taken 3/6/9
// [RULE9] Bus cycles are inside the total count
// [RULE10] Copy term scales with transfer count
// [RULE11] Shift count never changes shift timing
// [RULE12] Report best, cache, worst and r/p/w counts
`timescale 1ns/1ps
`include "ictm_consts.svh"
module ictm_top
   import ictm_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Request
   input wire logic req_valid,
   input wire logic [4:0] req_op,
   input wire logic req_mem,
   input wire logic [3:0] req_span_bytes,
   input wire logic [7:0] req_xfers,
   input wire logic [5:0] req_shift_count,
   // Answer
   output logic res_valid,
   output logic [7:0] res_best,
   output logic [7:0] res_cache,
   output logic [7:0] res_worst,
   output logic [7:0] res_rd,
   output logic [7:0] res_pf,
   output logic [7:0] res_wr,
   output logic res_add_ea
);
   // =====================================================
   // Operation
   // =====================================================
   // Request taken on a rising edge while idle
   // Same edge: table row ready
   // Edge after: res_valid high for one cycle
   // Answer fields held until the next answer
   // Requests while busy dropped, with no sign
   // Callers keep three cycles between requests
   //
   // Totals: best case, cache case, worst case
   // Read, prefetch and write counts sit inside the totals
   // Never added on top of them
   // Prefetch count is the worst case one
   // Best and cache cases fetch nothing
   //
   // res_add_ea: caller must still add an address time
   // Set for memory field ops
   // Set for single compare-and-swap
   // Set for both jump forms
   // Clear for branches, complete as they stand
   //
   // Stack copy term wraps at eight bits
   // Large transfer counts give totals modulo 256
   // Wider answers need wider answer fields
   //
   // Stray codes past the last row read as zero
   // Zero answer rather than a stale one
   //
   // One clock; reset asynchronous, active low
   // Inputs come from logic on this clock
   // Hence no synchroniser on the request lines

   // =====================================================
   // State
   // =====================================================
   ictm_regs_t q; // Registered state
   ictm_regs_t d; // Next state
   logic [47:0] row; // Table row for q.idx
   logic [5:0] idx_n; // Decoded table index
   logic ea_n; // Address time to be added
   logic [7:0] scale_clk; // Per-transfer clock term
   logic [7:0] scale_rw; // Per-transfer bus term
   // State register: sequencer, latched request, answer fields
   // Only the answer fields and strobe reach the ports

   // Table lookup
   // Row comes out of a register: valid one edge after the index
   // Decode presents the new index in the cycle of the take
   ictm_rom u_rom (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .idx(idx_n),
      .row_q(row)
   );

   // =====================================================
   // Decode
   // =====================================================
   // Row map, one row per case
   // Rows 00-17: field ops, three rows each
   // Order per op: register, one cycle, two cycles
   // Rows 18-1e: branches and decrement-branches
   // Rows 1f-28: module calls, swaps and jumps
   // Codes past the jump forms: shifts
   // Shift count never reaches the index
   // Map a request onto a table row
   always_comb begin
      idx_n = q.idx;
      ea_n = 1'b0;
      // Only an idle sequencer decodes; else hold the index
      if (req_valid && q.st == ICTM_IDLE) begin
         if (req_op <= `ICTM_OP_FIELD_FFO) begin
            // Three rows per field op: register, one cycle, two cycles
            idx_n = 6'(req_op) * `ICTM_ROWS_PER_FIELD;
            // Register form stays on the first row
            if (req_mem) begin
               ea_n = 1'b1; // [RULE6]
               if (req_span_bytes > `ICTM_ONE_CYCLE_BYTES) begin
                  idx_n = idx_n + `ICTM_ROW_MEM_TWO; // [RULE1]
               end else begin
                  idx_n = idx_n + `ICTM_ROW_MEM_ONE; // [RULE2]
               end
            end
         end else if (req_op <= `ICTM_OP_DEC_TRUE) begin
            // Branch rows carry no added address time
            idx_n = `ICTM_IDX_BR + 6'(req_op - `ICTM_OP_BR_TAKEN); // [RULE8] [RULE3] [RULE4]
         end else if (req_op <= `ICTM_OP_JSUB) begin
            idx_n = `ICTM_IDX_CTRL + 6'(req_op - `ICTM_OP_CALL_T0);
            // Single swap and jumps add address time
            ea_n = (req_op == `ICTM_OP_CAS_OK) || (req_op == `ICTM_OP_CAS_FAIL)
               || (req_op == `ICTM_OP_JUMP) || (req_op == `ICTM_OP_JSUB); // [RULE6] [RULE7]
         end else begin
            // Shift: count is ignored, shared 5/8/8 register row
            idx_n = `ICTM_IDX_SHIFT; // [RULE11]
         end
      end
   end

   // Copy call: the only row with a variable term
   // Six clocks per operand transfer
   // One read and one write per transfer
   // Product cut to eight bits on purpose
   // Stack-copy variable term
   always_comb begin
      if (q.idx == `ICTM_IDX_COPY) begin
         scale_clk = 8'(q.xfer * `ICTM_CLK_PER_XFER); // [RULE5] [RULE10]
         scale_rw = 8'(q.xfer * `ICTM_RW_PER_XFER); // [RULE10]
      end else begin
         // No variable term for other rows
         scale_clk = 8'h00;
         scale_rw = 8'h00;
      end
   end

   // =====================================================
   // Sequencer
   // =====================================================
   // Idle, wait for table row, present result for one cycle
   // Idle: latch index, transfer count, address flag
   // Table registers its row on that same edge
   // Look: add variable term, load answer fields
   // Done: strobe falls, which spaces requests
   // Other codes: back to idle
   always_comb begin
      d = q;
      d.valid = 1'b0;
      case (q.st)
         ICTM_IDLE: begin
            // Take a request only here
            if (req_valid) begin
               d.idx = idx_n;
               d.xfer = req_xfers;
               d.addr_add = ea_n;
               d.st = ICTM_LOOK;
            end
         end
         ICTM_LOOK: begin
            // Bus cycles already counted within totals
            // Prefetch never scales with transfers
            d.best = row[`ICTM_F_BEST] + scale_clk; // [RULE9] [RULE12]
            d.cache = row[`ICTM_F_CACHE] + scale_clk; // [RULE12]
            d.worst = row[`ICTM_F_WORST] + scale_clk; // [RULE12]
            d.rd = row[`ICTM_F_RD] + scale_rw; // [RULE5]
            d.pf = row[`ICTM_F_PF];
            d.wr = row[`ICTM_F_WR] + scale_rw; // [RULE5]
            d.add_ea = q.addr_add;
            d.valid = 1'b1;
            d.st = ICTM_DONE;
         end
         ICTM_DONE: begin
            // Strobe falls
            d.st = ICTM_IDLE;
         end
         default: begin
            // Unused code: recover
            d.st = ICTM_IDLE;
         end
      endcase
   end

   // State register
   // Asynchronous reset clears every field but st, which loads ICTM_IDLE
   // All outputs read zero until the first answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: ICTM_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flops
   // One state field per port
   // No logic between flop and pin
   assign res_valid = q.valid;
   assign res_best = q.best;
   assign res_cache = q.cache;
   assign res_worst = q.worst;
   assign res_rd = q.rd;
   assign res_pf = q.pf;
   assign res_wr = q.wr;
   assign res_add_ea = q.add_ea;
endmodule // ictm_top

// File: verif/ictm_props.sv
// Checker for the timing model answer port
`timescale 1ns/1ps
module ictm_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Request
   input wire logic req_valid,
   input wire logic [4:0] req_op,
   input wire logic req_mem,
   input wire logic [3:0] req_span_bytes,
   input wire logic [7:0] req_xfers,
   input wire logic [5:0] req_shift_count,
   // Answer
   input wire logic res_valid,
   input wire logic [7:0] res_best,
   input wire logic [7:0] res_cache,
   input wire logic [7:0] res_worst,
   input wire logic [7:0] res_rd,
   input wire logic [7:0] res_pf,
   input wire logic [7:0] res_wr,
   input wire logic res_add_ea
);
   // ==========================================
   // Answer timing and values
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_ans_lat: assert property (req_valid |-> ##2 res_valid)
      else $error("answer not two cycles after request");
   chk_one_pulse: assert property (res_valid |=> !res_valid)
      else $error("answer strobe longer than one cycle");
   chk_no_spur: assert property (res_valid |-> $past(req_valid, 2))
      else $error("answer without request");
   chk_dec_live: assert property (req_valid && req_op == 5'h0c |-> ##2
      {res_best, res_cache, res_worst, res_rd, res_pf, res_wr} == 48'h03_06_09_00_02_00)
      else $error("live decrement branch timing wrong");
   chk_dec_out: assert property (req_valid && req_op == 5'h0d |-> ##2
      {res_best, res_cache, res_worst, res_rd, res_pf, res_wr} == 48'h07_0a_0a_00_03_00)
      else $error("expired decrement branch timing wrong");
   chk_copy_scale: assert property (req_valid && req_op == 5'h12 |-> ##2
      res_best == 8'h3f + 8'h06 * $past(req_xfers, 2) && res_wr == 8'h08 + $past(req_xfers, 2))
      else $error("stack copy call timing wrong");
   chk_jump_ea: assert property (req_valid && req_op == 5'h17 |-> ##2
      res_add_ea && {res_best, res_cache, res_worst} == 24'h01_04_07)
      else $error("jump timing wrong");
   chk_branch_whole: assert property (req_valid && req_op == 5'h08 |-> ##2
      !res_add_ea && {res_best, res_cache, res_worst, res_pf} == 32'h03_06_09_02)
      else $error("taken branch timing wrong");
   chk_span_cycles: assert property (req_valid && req_op == 5'h00 && req_mem |->
      ##2 res_add_ea && res_rd == ($past(req_span_bytes, 2) > 4'h4 ? 8'h02 : 8'h01))
      else $error("field operand cycle count wrong");
   chk_shift_flat: assert property (req_valid && req_op == 5'h19 |-> ##2
      {res_best, res_cache, res_worst} == 24'h05_08_08)
      else $error("shift timing depends on count");
endmodule // ictm_props
bind ictm_top ictm_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
   .req_op(req_op), .req_mem(req_mem), .req_span_bytes(req_span_bytes), .req_xfers(req_xfers),
   .req_shift_count(req_shift_count), .res_valid(res_valid), .res_best(res_best),
   .res_cache(res_cache), .res_worst(res_worst), .res_rd(res_rd), .res_pf(res_pf),
   .res_wr(res_wr), .res_add_ea(res_add_ea));

// File: verif/ictm_req_src.sv
// Request source standing in front of the timing model
`timescale 1ns/1ps
module ictm_req_src (
   // Clock
   input wire logic clk_sys,
   // Bench side
   input wire logic go,
   input wire logic [4:0] op,
   input wire logic mem,
   input wire logic [3:0] span,
   input wire logic [7:0] xfers,
   input wire logic [5:0] shift,
   // Request lines
   output logic req_valid = 1'b0,
   output logic [4:0] req_op = 5'h00,
   output logic req_mem = 1'b0,
   output logic [3:0] req_span_bytes = 4'h0,
   output logic [7:0] req_xfers = 8'h00,
   output logic [5:0] req_shift_count = 6'h00
);
   // ==========================================
   // Launch on falling edge; idle lines toggle so no stale value looks valid
   always @(negedge clk_sys) begin
      req_valid <= go;
      req_op <= go ? op : ~req_op;
      req_mem <= go ? mem : ~req_mem;
      req_span_bytes <= go ? span : ~req_span_bytes;
      req_xfers <= go ? xfers : ~req_xfers;
      req_shift_count <= go ? shift : ~req_shift_count;
   end
endmodule // ictm_req_src

// File: verif/tb_ictm_top.sv
// Self-checking bench for the timing model
`timescale 1ns/1ps
module tb_ictm_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic go = 1'b0;
   logic [4:0] op = 5'h00;
   logic mem = 1'b0;
   logic [3:0] span = 4'h0;
   logic [7:0] xfers = 8'h00;
   logic [5:0] shift = 6'h00;
   logic rv, rm, vld, ea;
   logic [4:0] ro;
   logic [3:0] rs;
   logic [7:0] rx, b, c, w, rd, pf, wr;
   logic [5:0] rsh;
   logic [48:0] exp_q[$];
   logic [48:0] exp_v;
   int error_cnt = 0;
   int total_checks = 0;
   // ==========================================
   // Clock, source and model
   always #2.5 clk_sys = ~clk_sys;
   ictm_req_src u_src (.clk_sys(clk_sys), .go(go), .op(op), .mem(mem), .span(span),
      .xfers(xfers), .shift(shift), .req_valid(rv), .req_op(ro), .req_mem(rm),
      .req_span_bytes(rs), .req_xfers(rx), .req_shift_count(rsh));
   ictm_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(rv), .req_op(ro), .req_mem(rm),
      .req_span_bytes(rs), .req_xfers(rx), .req_shift_count(rsh), .res_valid(vld),
      .res_best(b), .res_cache(c), .res_worst(w), .res_rd(rd), .res_pf(pf), .res_wr(wr),
      .res_add_ea(ea));
   // ==========================================
   // Compare and finish
   task check(input logic [48:0] seen, input logic [48:0] want);
      total_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One request, expectation noted; spaced four cycles
   task send(input logic [4:0] o, input logic m, input logic [3:0] s, input logic [7:0] n,
         input logic [48:0] e);
      @(posedge clk_sys);
      #1;
      op = o;
      mem = m;
      span = s;
      xfers = n;
      shift = 6'($urandom);
      go = 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      #1 go = 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   // Monitor takes the oldest note on each answer
   always @(negedge clk_sys) begin
      if (vld === 1'b1) begin
         exp_v = exp_q.size() ? exp_q.pop_front() : 'x;
         check({ea, b, c, w, rd, pf, wr}, exp_v);
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      logic [7:0] n;
      void'($urandom(32'h0e720de2));
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys) rst_n = 1'b1;
      send(5'h00, 1'b0, 4'h4, 8'h00, {1'b0, 48'h03_06_07_00_01_00});
      send(5'h00, 1'b1, 4'h4, 8'h00, {1'b1, 48'h0b_0b_0c_01_01_00});
      send(5'h00, 1'b1, 4'h5, 8'h00, {1'b1, 48'h0f_0f_10_02_01_00});
      send(5'h06, 1'b1, 4'h5, 8'h00, {1'b1, 48'h14_14_15_02_01_02});
      send(5'h08, 1'b0, 4'h0, 8'h00, {1'b0, 48'h03_06_09_00_02_00});
      send(5'h09, 1'b0, 4'h0, 8'h00, {1'b0, 48'h01_04_05_00_01_00});
      send(5'h0c, 1'b0, 4'h0, 8'h00, {1'b0, 48'h03_06_09_00_02_00});
      send(5'h0d, 1'b0, 4'h0, 8'h00, {1'b0, 48'h07_0a_0a_00_03_00});
      send(5'h13, 1'b1, 4'h0, 8'h00, {1'b1, 48'h0f_0f_10_01_01_01});
      send(5'h17, 1'b0, 4'h0, 8'h00, {1'b1, 48'h01_04_07_00_02_00});
      send(5'h18, 1'b0, 4'h0, 8'h00, {1'b1, 48'h03_05_0b_00_02_01});
      // Remaining field, branch and control codes but the copy call, plus shift code 1f, one request each
      send(5'h01, 1'b1, 4'h4, 8'h00, {1'b1, 48'h10_10_10_01_01_01});
      send(5'h02, 1'b0, 4'h5, 8'h00, {1'b0, 48'h09_0c_0c_00_01_00});
      send(5'h03, 1'b1, 4'h5, 8'h00, {1'b1, 48'h18_18_18_02_01_02});
      send(5'h04, 1'b0, 4'h0, 8'h00, {1'b0, 48'h05_08_08_00_01_00});
      send(5'h05, 1'b1, 4'h1, 8'h00, {1'b1, 48'h0d_0d_0d_01_01_00});
      send(5'h07, 1'b1, 4'(5 + $urandom % 11), 8'h00,
         {1'b1, 48'h20_20_20_02_01_00});
      send(5'h0a, 1'b0, 4'h0, 8'h00, {1'b0, 48'h03_06_07_00_01_00});
      send(5'h0b, 1'b0, 4'h0, 8'h00, {1'b0, 48'h03_06_09_00_02_00});
      send(5'h0e, 1'b0, 4'h0, 8'h00, {1'b0, 48'h03_06_07_00_01_00});
      send(5'h0f, 1'b0, 4'h0, 8'h00, {1'b0, 48'h1c_1e_24_02_02_06});
      send(5'h10, 1'b0, 4'h0, 8'h00, {1'b0, 48'h30_32_38_05_02_08});
      send(5'h11, 1'b0, 4'h0, 8'h00, {1'b0, 48'h37_39_40_06_02_08});
      send(5'h14, 1'b1, 4'h0, 8'h00, {1'b1, 48'h0c_0c_0d_01_01_00});
      send(5'h15, 1'b1, 4'h0, 8'h00, {1'b0, 48'h17_19_1c_02_02_02});
      send(5'h16, 1'b0, 4'h0, 8'h00, {1'b0, 48'h13_16_19_02_02_00});
      send(5'h1f, 1'b0, 4'h0, 8'h00, {1'b0, 48'h05_08_08_00_01_00});
      // Copy call: zero, wrap boundary and random transfer counts, each followed by a shift request
      for (int i = 0; i < 5; i++) begin
         n = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom % 40);
         send(5'h12, 1'b0, 4'h0, n, {1'b0, 8'(63 + 6 * n), 8'(65 + 6 * n), 8'(71 + 6 * n),
            8'(7 + n), 8'h02, 8'(8 + n)});
         send(5'h19, 1'b0, 4'h0, 8'h00, {1'b0, 48'h05_08_08_00_01_00});
      end
      repeat (4) @(posedge clk_sys);
      check(49'(exp_q.size()), 49'h0);
      give_verdict();
   end
   // Watchdog
   initial begin
      repeat (600) @(posedge clk_sys);
      error_cnt++;
      give_verdict();
   end
endmodule // tb_ictm_top
